//--- design/ea_gen_defs.vh
// Constants for the effective-address generator
`ifndef EA_GEN_DEFS_VH
`define EA_GEN_DEFS_VH
// Addressing modes presented by the decoder
`define MODE_POST_INC 3'h0
`define MODE_PRE_DEC 3'h1
`define MODE_SHORT_ABS 3'h2
`define MODE_LONG_ABS 3'h3
`define MODE_PC_REL 3'h4
`define MODE_MEM_IND 3'h5
`define MODE_BLOCK 3'h6
`define MODE_IMM 3'h7
// Instruction classes
`define CLS_BYTE_MOVE 3'h0
`define CLS_WORD_MOVE 3'h1
`define CLS_BIT_MANIP 3'h2
`define CLS_JUMP 3'h3
`define CLS_SUB_CALL 3'h4
`define CLS_BRANCH 3'h5
`define CLS_ADD_SUB_SMALL 3'h6
`define CLS_OTHER 3'h7
// Fixed values
`define SHORT_ABS_PAGE 8'hFF
`define STEP_BYTE 16'h0001
`define STEP_WORD 16'h0002
`define ADDR_RESET 16'h0000
`endif

//--- design/addr_adder.v
// Combinational 16-bit address adder that adds or subtracts the step
`timescale 1ns/1ns
`default_nettype none
module addr_adder (
  input wire [15:0] base,
  input wire [15:0] step,
  input wire subtract,
  output wire [15:0] result
);
  // Two's complement subtract keeps one adder for both directions
  assign result = subtract ? (base - step) : (base + step);
endmodule // addr_adder
`default_nettype wire

//--- design/cpu_effective_address_generator.v
// Effective-address generation and operand fetch sequencing
// Operation
// RQ1 - Post-increment: address, then add 1 or 2
// RQ2 - Pre-decrement: subtract 1 or 2, then address
// RQ3 - Software keeps word pointer even
// RQ4 - Short absolute forces upper byte to ones
// RQ5 - Short absolute only for byte/bit ops
// RQ6 - Long absolute for moves, jumps, calls
// RQ7 - Immediate from byte 2, or 3 and 4
// RQ8 - 16-bit immediate only for word moves
// RQ9 - Add/subtract small constant implies 1 or 2
// RQ10 - Bit number from byte 2 or 4
// RQ11 - Sign-extended displacement added to PC
// RQ12 - Software uses even displacements
// RQ13 - Memory indirect reads branch target word
// RQ14 - Block move: count, source, destination registers
// RQ15 - Software keeps destination below top address
// RQ16 - Block move steps pointers, decrements count
`timescale 1ns/1ns
`default_nettype none
`include "ea_gen_defs.vh"
module cpu_effective_address_generator (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Instruction decoder and register file
  input wire start,
  input wire [2:0] mode,
  input wire [2:0] instr_class,
  input wire [7:0] byte2,
  input wire [7:0] byte3,
  input wire [7:0] byte4,
  input wire imm_long,
  input wire small_const_two,
  input wire bit_from_byte4,
  input wire [15:0] pc,
  input wire [15:0] reg_value,
  input wire [15:0] block_count_reg,
  input wire [15:0] block_source_reg,
  input wire [15:0] block_dest_reg,
  // Memory bus answer
  input wire [15:0] mem_rdata,
  input wire mem_ack,
  // Memory request
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  output reg mem_req,
  output reg mem_we,
  output reg mem_word,
  // Address, operand and write-back results
  output reg [15:0] ea_out,
  output reg [15:0] imm_out,
  output reg [2:0] bit_num,
  output reg [15:0] reg_wb_value,
  output reg reg_wb,
  output reg [15:0] block_count_wb,
  output reg [15:0] block_source_wb,
  output reg [15:0] block_dest_wb,
  output reg block_wb,
  output reg done,
  output reg illegal
);
  // Sequencer states
  localparam ST_IDLE = 3'h0;
  localparam ST_IND = 3'h1;
  localparam ST_BLK_RD = 3'h2;
  localparam ST_BLK_WR = 3'h3;
  localparam ST_FIN = 3'h4;

  // Sequencer state and block-move working copies
  reg [2:0] state_q;
  reg [7:0] blk_cnt_q;
  reg [15:0] blk_src_q;
  reg [15:0] blk_dst_q;
  // Decode helpers
  wire is_word;
  wire [15:0] step;
  wire [15:0] step_sum;
  wire [15:0] pc_target;
  wire legal;

  // Decode whether an instruction class may use a mode
  function mode_legal;
    input [2:0] m;
    input [2:0] c;
    input il;
    begin
      case (m)
        `MODE_SHORT_ABS: mode_legal = (c == `CLS_BYTE_MOVE) ||
          (c == `CLS_BIT_MANIP); // [RQ5]
        `MODE_LONG_ABS: mode_legal = (c == `CLS_BYTE_MOVE) || (c == `CLS_WORD_MOVE) ||
          (c == `CLS_JUMP) || (c == `CLS_SUB_CALL); // [RQ6]
        `MODE_POST_INC, `MODE_PRE_DEC: mode_legal = (c == `CLS_BYTE_MOVE) ||
          (c == `CLS_WORD_MOVE);
        `MODE_PC_REL: mode_legal = (c == `CLS_BRANCH) || (c == `CLS_SUB_CALL);
        `MODE_MEM_IND: mode_legal = (c == `CLS_JUMP) || (c == `CLS_SUB_CALL);
        `MODE_IMM: mode_legal = !il || (c == `CLS_WORD_MOVE); // [RQ8]
        `MODE_BLOCK: mode_legal = 1'b1; // Block move has no class limit
        default: mode_legal = 1'b1;
      endcase
    end
  endfunction

  // Bit number comes from byte 2 or byte 4
  function [2:0] bit_select;
    input from4;
    input [7:0] b2;
    input [7:0] b4;
    begin
      bit_select = from4 ? b4[2:0] : b2[2:0]; // [RQ10]
    end
  endfunction

  // Short addresses always land in the top page
  function [15:0] top_page_addr;
    input [7:0] low;
    begin
      top_page_addr = {`SHORT_ABS_PAGE, low}; // [RQ4]
    end
  endfunction

  // Step size follows the transfer width
  assign is_word = (instr_class == `CLS_WORD_MOVE);
  assign step = is_word ? `STEP_WORD : `STEP_BYTE; // [RQ1] [RQ2]
  assign legal = mode_legal(mode, instr_class, imm_long);

  // Shared adder: post-increment adds, pre-decrement subtracts
  addr_adder u_step (
    .base(reg_value),
    .step(step),
    .subtract(mode == `MODE_PRE_DEC),
    .result(step_sum)
  );

  // Sign-extend the displacement before adding it to the PC
  assign pc_target = pc + {{8{byte2[7]}}, byte2}; // [RQ11]

  // Main sequencer; outputs are all registered
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // Every output starts cleared
      state_q <= ST_IDLE;
      blk_cnt_q <= 8'h00;
      blk_src_q <= `ADDR_RESET;
      blk_dst_q <= `ADDR_RESET;
      mem_addr <= `ADDR_RESET;
      mem_wdata <= 8'h00;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_word <= 1'b0;
      ea_out <= `ADDR_RESET;
      imm_out <= 16'h0000;
      bit_num <= 3'h0;
      reg_wb_value <= `ADDR_RESET;
      reg_wb <= 1'b0;
      block_count_wb <= 16'h0000;
      block_source_wb <= `ADDR_RESET;
      block_dest_wb <= `ADDR_RESET;
      block_wb <= 1'b0;
      done <= 1'b0;
      illegal <= 1'b0;
    end else begin
      // Strobes last one cycle
      done <= 1'b0;
      reg_wb <= 1'b0;
      block_wb <= 1'b0;
      illegal <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // Only idle takes a request; starts while busy are dropped
          if (start) begin
            if (!legal) begin
              // Unsupported pairing is flagged, nothing issued
              illegal <= 1'b1;
              done <= 1'b1;
            end else begin
              case (mode)
                // Old value is the address, stepped value written back
                `MODE_POST_INC: begin
                  ea_out <= reg_value; // [RQ1]
                  reg_wb_value <= step_sum; // [RQ1]
                  reg_wb <= 1'b1;
                  done <= 1'b1;
                end
                // Stepped value is both address and write-back
                `MODE_PRE_DEC: begin
                  ea_out <= step_sum; // [RQ2]
                  reg_wb_value <= step_sum; // [RQ2]
                  reg_wb <= 1'b1;
                  done <= 1'b1;
                end
                // Top-page operand, bit number for bit operations
                `MODE_SHORT_ABS: begin
                  ea_out <= top_page_addr(byte2); // [RQ4]
                  bit_num <= bit_select(bit_from_byte4, byte2, byte4); // [RQ10]
                  done <= 1'b1;
                end
                // Full address from bytes 3 and 4
                `MODE_LONG_ABS: begin
                  ea_out <= {byte3, byte4}; // [RQ6]
                  bit_num <= bit_select(bit_from_byte4, byte2, byte4); // [RQ10]
                  done <= 1'b1;
                end
                // Branch target from the sign-extended offset
                `MODE_PC_REL: begin
                  ea_out <= pc_target; // [RQ11]
                  done <= 1'b1;
                end
                `MODE_MEM_IND: begin
                  // Fetch the target word from the top page
                  mem_addr <= top_page_addr(byte2); // [RQ13]
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_word <= 1'b1;
                  state_q <= ST_IND;
                end
                // Latch the three block registers before moving
                `MODE_BLOCK: begin
                  blk_cnt_q <= block_count_reg[7:0]; // [RQ14]
                  blk_src_q <= block_source_reg; // [RQ14]
                  blk_dst_q <= block_dest_reg; // [RQ14]
                  state_q <= ST_BLK_RD;
                end
                default: begin
                  // Immediate forms
                  if (instr_class == `CLS_ADD_SUB_SMALL)
                    imm_out <= small_const_two ? `STEP_WORD : `STEP_BYTE; // [RQ9]
                  else if (imm_long)
                    imm_out <= {byte3, byte4}; // [RQ7] [RQ8]
                  else
                    imm_out <= {8'h00, byte2}; // [RQ7]
                  bit_num <= bit_select(bit_from_byte4, byte2, byte4); // [RQ10]
                  done <= 1'b1;
                end
              endcase
            end
          end
        end

        // Wait for the target word
        ST_IND: begin
          if (mem_ack) begin
            ea_out <= mem_rdata; // [RQ13]
            mem_req <= 1'b0;
            done <= 1'b1;
            state_q <= ST_IDLE;
          end
        end

        ST_BLK_RD: begin
          // Zero count moves nothing
          if (blk_cnt_q == 8'h00) begin
            state_q <= ST_FIN;
          end else if (mem_req && mem_ack) begin
            mem_wdata <= mem_rdata[7:0];
            mem_addr <= blk_dst_q; // [RQ14]
            mem_we <= 1'b1;
            state_q <= ST_BLK_WR;
          end else begin
            // Keep requesting until the ack arrives
            mem_addr <= blk_src_q; // [RQ14]
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_word <= 1'b0;
          end
        end

        // Write the byte just read
        ST_BLK_WR: begin
          if (mem_ack) begin
            // Pointers wrap silently; software keeps destination in range
            blk_src_q <= blk_src_q + `STEP_BYTE; // [RQ16]
            blk_dst_q <= blk_dst_q + `STEP_BYTE; // [RQ16]
            blk_cnt_q <= blk_cnt_q - 8'h01; // [RQ16]
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state_q <= ST_BLK_RD;
          end
        end

        ST_FIN: begin
          // Hand back updated registers once the count is exhausted
          block_count_wb <= {block_count_reg[15:8], blk_cnt_q};
          block_source_wb <= blk_src_q;
          block_dest_wb <= blk_dst_q;
          block_wb <= 1'b1; // [RQ16]
          done <= 1'b1;
          state_q <= ST_IDLE;
        end

        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule // cpu_effective_address_generator
`default_nettype wire

//--- dv/ea_mem_model.sv
// Memory bus partner: fixed read pattern, records writes
`timescale 1ns/1ns
`default_nettype none
module ea_mem_model (
  input wire logic mclk, rst_n, mem_req, mem_we, slow,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [7:0] wr [0:65535];
  logic w_q;
  // One ack per request; slow adds a wait; idle data toggles so stale data cannot match
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
      w_q <= 1'b0;
    end else if (mem_req && !mem_ack && (!slow || w_q)) begin
      mem_ack <= 1'b1;
      w_q <= 1'b0;
      mem_rdata <= {mem_addr[7:0] ^ 8'h3C, mem_addr[15:8]};
      if (mem_we) wr[mem_addr] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      w_q <= mem_req;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // ea_mem_model
`default_nettype wire

//--- dv/cpu_effective_address_generator_assertions.sv
// Port assertions for the effective-address generator
`timescale 1ns/1ns
`default_nettype none
module ea_gen_chk (
  input wire logic mclk, rst_n, start, imm_long, mem_req, mem_we, mem_word, mem_ack,
  input wire logic reg_wb, block_wb, done, illegal,
  input wire logic [2:0] mode, instr_class,
  input wire logic [7:0] byte2,
  input wire logic [15:0] pc, reg_value, mem_addr, mem_rdata, ea_out, reg_wb_value,
  input wire logic [15:0] block_count_wb
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_pinc;
    start && mode == 3'h0 |=> reg_wb && ea_out == $past(reg_value) &&
      reg_wb_value == $past(reg_value) + ($past(instr_class) == 3'h1 ? 16'h0002 : 16'h0001);
  endproperty
  a_pinc: assert property (p_pinc) else $error("post-increment wrong");
  property p_pdec;
    start && mode == 3'h1 |=> reg_wb && ea_out == reg_wb_value &&
      reg_wb_value == $past(reg_value) - ($past(instr_class) == 3'h1 ? 16'h0002 : 16'h0001);
  endproperty
  a_pdec: assert property (p_pdec) else $error("pre-decrement wrong");
  property p_sabs;
    start && mode == 3'h2 && instr_class == 3'h0 |=> done && ea_out == {8'hFF, $past(byte2)};
  endproperty
  a_sabs: assert property (p_sabs) else $error("short absolute wrong");
  property p_sill;
    start && mode == 3'h2 && !(instr_class inside {3'h0, 3'h2}) |=> illegal && done;
  endproperty
  a_sill: assert property (p_sill) else $error("short absolute accepted");
  property p_labs;
    start && mode == 3'h3 |=> illegal == !($past(instr_class) inside {3'h0, 3'h1, 3'h3, 3'h4});
  endproperty
  a_labs: assert property (p_labs) else $error("long absolute class check");
  property p_imm;
    start && mode == 3'h7 && imm_long |=> illegal == ($past(instr_class) != 3'h1);
  endproperty
  a_imm: assert property (p_imm) else $error("long immediate check");
  property p_pcrel;
    start && mode == 3'h4 |=> ea_out == $past(pc) + {{8{$past(byte2[7])}}, $past(byte2)};
  endproperty
  a_pcrel: assert property (p_pcrel) else $error("relative target wrong");
  property p_mind;
    start && mode == 3'h5 |=> mem_req && mem_word && !mem_we && mem_addr == {8'hFF, $past(byte2)};
  endproperty
  a_mind: assert property (p_mind) else $error("indirect fetch wrong");
  property p_mtgt;
    mem_req && mem_word && mem_ack |=> done && ea_out == $past(mem_rdata);
  endproperty
  a_mtgt: assert property (p_mtgt) else $error("indirect target wrong");
  property p_blk;
    block_wb |-> done && block_count_wb[7:0] == 8'h00;
  endproperty
  a_blk: assert property (p_blk) else $error("block end count wrong");
  c_blk: cover property (block_wb);
  c_ill: cover property (illegal);
  c_mind: cover property (mem_req && mem_word && mem_ack);
endmodule // ea_gen_chk
`default_nettype wire

//--- dv/cpu_effective_address_generator_tb.sv
// Self-checking bench for the effective-address generator
`timescale 1ns/1ns
`default_nettype none
module cpu_effective_address_generator_tb;
  logic mclk, rst_n, start, imm_long, small_const_two, bit_from_byte4, slow;
  logic mem_ack, mem_req, mem_we, mem_word, reg_wb, block_wb, done, illegal, e;
  logic [2:0] mode, instr_class, bit_num;
  logic [7:0] byte2, byte3, byte4, mem_wdata;
  logic [15:0] pc, reg_value, block_count_reg, block_source_reg, block_dest_reg, mem_rdata;
  logic [15:0] mem_addr, ea_out, imm_out, reg_wb_value, block_count_wb, block_source_wb;
  logic [15:0] block_dest_wb, v, s;
  int error_cnt, checked, n, k;
  cpu_effective_address_generator i_cpu_effective_address_generator (.mclk, .rst_n, .start,
    .mode, .instr_class, .byte2, .byte3, .byte4, .imm_long, .small_const_two, .bit_from_byte4,
    .pc, .reg_value, .block_count_reg, .block_source_reg, .block_dest_reg, .mem_rdata,
    .mem_ack, .mem_addr, .mem_wdata, .mem_req, .mem_we, .mem_word, .ea_out, .imm_out,
    .bit_num, .reg_wb_value, .reg_wb, .block_count_wb, .block_source_wb, .block_dest_wb,
    .block_wb, .done, .illegal);
  ea_mem_model i_ea_mem_model (.mclk, .rst_n, .mem_req, .mem_we, .slow, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata);
  function automatic logic [15:0] rd(input logic [15:0] a);
    return {a[7:0] ^ 8'h3C, a[15:8]};
  endfunction
  task automatic chk(input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Start pulse off the rising edge, then a bounded wait for done
  task automatic go(input logic [2:0] m, c);
    @(negedge mclk);
    {mode, instr_class, start} = {m, c, 1'b1};
    @(negedge mclk);
    start = 1'b0;
    for (n = 0; done !== 1'b1 && n < 3000; n++) @(negedge mclk);
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #1000000;
    error_cnt++;
    stop_test;
  end
  initial begin
    {start, imm_long, small_const_two, bit_from_byte4, slow, mode, instr_class} = '0;
    {byte2, byte3, byte4, pc, reg_value, block_count_reg} = '0;
    {block_source_reg, block_dest_reg, rst_n} = '0;
    void'($urandom(6));
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      s = i[0] ? 16'h0002 : 16'h0001;
      v = (i[1] ? 16'($urandom) : (i[2] ? 16'h0000 : 16'hFFFE)) & ~{15'h0000, i[0]};
      reg_value = v;
      go({2'b00, i[2]}, {2'b00, i[0]});
      chk(reg_wb, 1'b1);
      chk(ea_out, i[2] ? v - s : v);
      chk(reg_wb_value, i[2] ? v - s : v + s);
    end
    for (int i = 0; i < 16; i++) begin
      {byte2, byte3, byte4, bit_from_byte4} = 25'($urandom);
      go(i[3] ? 3'h3 : 3'h2, i[2:0]);
      e = i[3] ? i[2:0] inside {3'h0, 3'h1, 3'h3, 3'h4} : i[2:0] inside {3'h0, 3'h2};
      chk(illegal, !e);
      if (e) chk(ea_out, i[3] ? {byte3, byte4} : {8'hFF, byte2});
      if (i == 2) chk(bit_num, bit_from_byte4 ? byte4[2:0] : byte2[2:0]);
    end
    for (int i = 0; i < 4; i++) begin
      {byte2, byte3, byte4, small_const_two} = 25'($urandom);
      imm_long = i inside {1, 2};
      go(3'h7, i == 3 ? 3'h6 : {2'b00, i == 2});
      chk(illegal, i == 1);
      if (i != 1) chk(imm_out, i == 3 ? (small_const_two ? 16'h0002 : 16'h0001) :
        (i == 2 ? {byte3, byte4} : {8'h00, byte2}));
    end
    imm_long = 1'b0;
    for (int i = 0; i < 6; i++) begin
      pc = 16'($urandom);
      byte2 = i == 0 ? 8'h80 : (i == 1 ? 8'h7E : 8'($urandom) & 8'hFE);
      go(3'h4, 3'h5);
      chk(ea_out, pc + {{8{byte2[7]}}, byte2});
    end
    for (int i = 0; i < 4; i++) begin
      byte2 = 8'($urandom);
      slow = i[0];
      go(3'h5, i[1] ? 3'h4 : 3'h3);
      chk(ea_out, rd({8'hFF, byte2}));
    end
    for (int i = 0; i < 4; i++) begin
      k = i < 2 ? i : $urandom_range(2, 20);
      block_count_reg = {8'($urandom), 8'(k)};
      block_source_reg = 16'($urandom_range(0, 16'hF000));
      block_dest_reg = 16'($urandom_range(0, 16'hF000));
      slow = $urandom;
      go(3'h6, 3'h7);
      chk(block_wb, 1'b1);
      chk(block_count_wb[7:0], 8'h00);
      chk(block_source_wb, block_source_reg + 16'(k));
      chk(block_dest_wb, block_dest_reg + 16'(k));
      for (int j = 0; j < k; j++)
        chk(i_ea_mem_model.wr[block_dest_reg + 16'(j)], rd(block_source_reg + 16'(j)) & 16'h00FF);
    end
    stop_test;
  end
endmodule // cpu_effective_address_generator_tb
bind cpu_effective_address_generator ea_gen_chk i_ea_gen_chk (.*);
`default_nettype wire
